// ---- design/sps_params.svh ----
// Constants for the serial PLL synthesizer core.
// Assumes a single 100 MHz system clock; pins are asynchronous.
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_REF_WIDTH 16
`define SPS_MAIN_WIDTH 10
`define SPS_REF_RESET 16'h0005
`define SPS_MAIN_RESET 10'h005
`define SPS_MIN_FACTOR 5
`define SPS_SYNC_STAGES 3
`endif

// ---- design/sps_pkg.sv ----
// Types for the serial PLL synthesizer core.
// Assumes sps_params.svh is on the include path.
package sps_pkg;
   typedef logic [15:0] sps_ref_t;
   typedef logic [9:0] sps_main_t;
   typedef enum logic [2:0] {
      SPS_PD_IDLE = 3'b001,
      SPS_PD_UP = 3'b010,
      SPS_PD_DOWN = 3'b100
   } sps_pd_e;
endpackage

// ---- design/sps_divider.sv ----
// Programmable divider counting qualified input edges.
// Assumes the edge strobe is a one-cycle pulse in the clock_in domain.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_divider #(
   parameter int WIDTH = 16
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic edge_in,
   input wire logic [WIDTH-1:0] factor_in,
   output logic pulse_out
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic pulse_next;
   wire terminal = (count_reg <= WIDTH'(1));
   // ==========================================
   // Reload at terminal count
   assign count_next = !edge_in ? count_reg :
      (terminal ? factor_in : count_reg - WIDTH'(1));
   assign pulse_next = edge_in && terminal;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_reg <= '0;
         pulse_out <= 1'b0;
      end else begin
         count_reg <= count_next;
         pulse_out <= pulse_next;
      end
   end
   property p_one_pulse;
      @(posedge clock_in) disable iff (!rst_n_in)
      pulse_out |=> !pulse_out;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("divider pulse longer than one cycle");
   property p_reload;
      @(posedge clock_in) disable iff (!rst_n_in)
      (edge_in && terminal) |=> (count_reg == $past(factor_in));
   endproperty
   a_reload: assert property (p_reload)
      else $error("divider did not reload factor");
endmodule

// ---- design/sps_core.sv ----
// Serial PLL synthesizer core: serial load, dividers, phase detector.
// Assumes pin inputs are asynchronous to clock_in, and that the
// oscillator and VCO inputs are well below half the clock rate.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_core #(
   parameter int REF_WIDTH = `SPS_REF_WIDTH,
   parameter int MAIN_WIDTH = `SPS_MAIN_WIDTH
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic osc_amp_input_in,
   input wire logic freq_in,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic latch_load_strobe_in,
   output logic vco_side_compare_out,
   output logic ref_side_compare_out,
   output logic passive_filter_out,
   output logic passive_filter_oe_out,
   output logic active_filter_drive_out,
   output logic active_filter_drive_oe_out,
   output logic lock_indicator_out,
   output logic pump_vco_out,
   output logic pump_ref_out,
   output sps_pkg::sps_ref_t ref_factor_out,
   output sps_pkg::sps_main_t main_factor_out
);
   import sps_pkg::*;
   // ==========================================
   // Pin synchronisers
   logic [2:0] osc_sync_reg;
   logic [2:0] fin_sync_reg;
   logic [2:0] sck_sync_reg;
   logic [2:0] sdi_sync_reg;
   logic [2:0] le_sync_reg;
   logic osc_lvl_reg, fin_lvl_reg, sck_lvl_reg, sdi_lvl_reg, le_lvl_reg;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_sync_reg <= '0;
         fin_sync_reg <= '0;
         sck_sync_reg <= '0;
         sdi_sync_reg <= '0;
         le_sync_reg <= '0;
      end else begin
         osc_sync_reg <= {osc_sync_reg[1:0], osc_amp_input_in};
         fin_sync_reg <= {fin_sync_reg[1:0], freq_in};
         sck_sync_reg <= {sck_sync_reg[1:0], serial_clock_in};
         sdi_sync_reg <= {sdi_sync_reg[1:0], serial_data_in};
         le_sync_reg <= {le_sync_reg[1:0], latch_load_strobe_in};
      end
   end
   // Filtered levels change only when stages two and three agree
   function automatic logic filt(input logic [2:0] s, input logic old);
      filt = (s[2] == s[1]) ? s[2] : old;
   endfunction
   wire osc_lvl_next = filt(osc_sync_reg, osc_lvl_reg);
   wire fin_lvl_next = filt(fin_sync_reg, fin_lvl_reg);
   wire sck_lvl_next = filt(sck_sync_reg, sck_lvl_reg);
   wire sdi_lvl_next = filt(sdi_sync_reg, sdi_lvl_reg);
   wire le_lvl_next = filt(le_sync_reg, le_lvl_reg);
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_lvl_reg <= 1'b0;
         fin_lvl_reg <= 1'b0;
         sck_lvl_reg <= 1'b0;
         sdi_lvl_reg <= 1'b0;
         le_lvl_reg <= 1'b0;
      end else begin
         osc_lvl_reg <= osc_lvl_next;
         fin_lvl_reg <= fin_lvl_next;
         sck_lvl_reg <= sck_lvl_next;
         sdi_lvl_reg <= sdi_lvl_next;
         le_lvl_reg <= le_lvl_next;
      end
   end
   wire osc_rise = osc_lvl_next && !osc_lvl_reg;
   wire fin_rise = fin_lvl_next && !fin_lvl_reg;
   wire sck_rise = sck_lvl_next && !sck_lvl_reg;
   // ==========================================
   // Serial shift register and latches
   logic [REF_WIDTH:0] shift_reg;
   wire [REF_WIDTH:0] shift_next = sck_rise ?
      {shift_reg[REF_WIDTH-1:0], sdi_lvl_next} : shift_reg;
   wire ctrl_bit = shift_reg[0];
   wire load_ref = le_lvl_reg && ctrl_bit;
   wire load_main = le_lvl_reg && !ctrl_bit;
   sps_ref_t ref_latch_reg;
   sps_main_t main_latch_reg;
   wire [REF_WIDTH-1:0] ref_latch_next =
      load_ref ? shift_reg[REF_WIDTH:1] : ref_latch_reg;
   wire [MAIN_WIDTH-1:0] main_latch_next =
      load_main ? shift_reg[MAIN_WIDTH:1] : main_latch_reg;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_reg <= '0;
         ref_latch_reg <= `SPS_REF_RESET;
         main_latch_reg <= `SPS_MAIN_RESET;
      end else begin
         shift_reg <= shift_next;
         ref_latch_reg <= ref_latch_next;
         main_latch_reg <= main_latch_next;
      end
   end
   assign ref_factor_out = ref_latch_reg;
   assign main_factor_out = main_latch_reg;
   // ==========================================
   // Dividers
   logic ref_pulse, main_pulse;
   sps_divider #(.WIDTH(REF_WIDTH)) u_ref_div (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .edge_in(osc_rise),
      .factor_in(ref_latch_reg),
      .pulse_out(ref_pulse)
   );
   sps_divider #(.WIDTH(MAIN_WIDTH)) u_main_div (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .edge_in(fin_rise),
      .factor_in(main_latch_reg),
      .pulse_out(main_pulse)
   );
   assign ref_side_compare_out = ref_pulse;
   assign vco_side_compare_out = main_pulse;
   // ==========================================
   // Phase/frequency detector
   sps_pd_e pd_reg, pd_next;
   always_comb begin
      pd_next = pd_reg;
      unique case (pd_reg)
         SPS_PD_IDLE: begin
            if (ref_pulse && !main_pulse) pd_next = SPS_PD_UP;
            else if (main_pulse && !ref_pulse) pd_next = SPS_PD_DOWN;
         end
         SPS_PD_UP: begin
            if (main_pulse) pd_next = SPS_PD_IDLE;
         end
         SPS_PD_DOWN: begin
            if (ref_pulse) pd_next = SPS_PD_IDLE;
         end
         default: pd_next = SPS_PD_IDLE;
      endcase
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pd_reg <= SPS_PD_IDLE;
      end else begin
         pd_reg <= pd_next;
      end
   end
   wire pd_up = (pd_reg == SPS_PD_UP);
   wire pd_down = (pd_reg == SPS_PD_DOWN);
   assign passive_filter_out = pd_up;
   assign passive_filter_oe_out = pd_up || pd_down;
   assign active_filter_drive_out = pd_down;
   assign active_filter_drive_oe_out = pd_up || pd_down;
   assign lock_indicator_out = !(pd_up || pd_down);
   assign pump_ref_out = !pd_up;
   assign pump_vco_out = !pd_down;
   // ==========================================
   // Checks
   property p_shift;
      @(posedge clock_in) disable iff (!rst_n_in)
      sck_rise |=> shift_reg[0] == $past(sdi_lvl_next);
   endproperty
   a_shift: assert property (p_shift)
      else $error("serial bit not shifted in");
   property p_hold;
      @(posedge clock_in) disable iff (!rst_n_in)
      !le_lvl_reg |=> $stable(ref_latch_reg) && $stable(main_latch_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("latch changed with strobe low");
   property p_load_ref;
      @(posedge clock_in) disable iff (!rst_n_in)
      (le_lvl_reg && shift_reg[0]) |=>
         ref_latch_reg == $past(shift_reg[REF_WIDTH:1]);
   endproperty
   a_load_ref: assert property (p_load_ref)
      else $error("reference latch not loaded");
   property p_load_main;
      @(posedge clock_in) disable iff (!rst_n_in)
      (le_lvl_reg && !shift_reg[0]) |=>
         main_latch_reg == $past(shift_reg[MAIN_WIDTH:1]);
   endproperty
   a_load_main: assert property (p_load_main)
      else $error("main latch not loaded");
   property p_passive;
      @(posedge clock_in) disable iff (!rst_n_in)
      (ref_pulse && !main_pulse && pd_reg == SPS_PD_IDLE) |=>
         passive_filter_oe_out && passive_filter_out;
   endproperty
   a_passive: assert property (p_passive)
      else $error("passive filter not driven high");
   property p_active;
      @(posedge clock_in) disable iff (!rst_n_in)
      (main_pulse && !ref_pulse && pd_reg == SPS_PD_IDLE) |=>
         active_filter_drive_oe_out && active_filter_drive_out;
   endproperty
   a_active: assert property (p_active)
      else $error("active filter not driven high");
   property p_lock;
      @(posedge clock_in) disable iff (!rst_n_in)
      lock_indicator_out == !passive_filter_oe_out;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock indicator disagrees with detector");
   property p_pump;
      @(posedge clock_in) disable iff (!rst_n_in)
      !(pump_ref_out == 1'b0 && pump_vco_out == 1'b0);
   endproperty
   a_pump: assert property (p_pump)
      else $error("both pump outputs active");
endmodule

// ---- tb/sps_host_model.sv ----
// Host model: drives the three-wire serial programming link.
// Assumes one caller at a time and the bench clock on clock_in.
`timescale 1ns/1ps
module sps_host_model (
   input wire logic clock_in,
   output logic serial_clock_out,
   output logic serial_data_out,
   output logic latch_load_strobe_out
);
   // ====================
   // Idle levels
   initial begin
      serial_clock_out = 1'b0;
      serial_data_out = 1'b0;
      latch_load_strobe_out = 1'b0;
   end
   // ====================
   // Word sender, hold is cycles per level
   task automatic send(input logic [15:0] val, input int nbits,
      input logic ctrl, input logic load, input int hold);
      logic b;
      for (int i = nbits; i >= 0; i--) begin
         b = (i == 0) ? ctrl : val[i-1];
         @(negedge clock_in) serial_data_out = b;
         repeat (hold) @(negedge clock_in);
         serial_clock_out = 1'b1;
         repeat (hold) @(negedge clock_in);
         serial_clock_out = 1'b0;
      end
      repeat (hold) @(negedge clock_in);
      serial_data_out = ~b;
      latch_load_strobe_out = load;
      repeat (2 * hold) @(negedge clock_in);
      latch_load_strobe_out = 1'b0;
      repeat (hold) @(negedge clock_in);
   endtask
endmodule

// ---- tb/sps_core_bench.sv ----
// Bench for the synthesizer core: programs factors, runs dividers.
// Assumes sps_pkg is compiled and sps_params.svh is on the path.
`timescale 1ns/1ps
module sps_core_bench;
   import sps_pkg::*;
   logic clock_in, rst_n_in, osc_amp_input_in, freq_in;
   logic serial_clock_in, serial_data_in, latch_load_strobe_in;
   logic vco_side_compare_out, ref_side_compare_out;
   logic passive_filter_out, passive_filter_oe_out;
   logic active_filter_drive_out, active_filter_drive_oe_out;
   logic lock_indicator_out, pump_vco_out, pump_ref_out;
   sps_ref_t ref_factor_out;
   sps_main_t main_factor_out;
   int mismatches = 0, checked = 0, cycles = 0, ph = 0;
   int ref_exp = 5, main_exp = 5, st = 0, wait_pd = 0;
   int osc_edges = 0, frq_edges = 0;
   int rq[$], vq[$];
   logic osc_en = 1'b0, frq_en = 1'b0;
   logic [31:0] seed = 32'h3202b7cb;

   sps_core dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .osc_amp_input_in(osc_amp_input_in), .freq_in(freq_in),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .latch_load_strobe_in(latch_load_strobe_in),
      .vco_side_compare_out(vco_side_compare_out),
      .ref_side_compare_out(ref_side_compare_out),
      .passive_filter_out(passive_filter_out),
      .passive_filter_oe_out(passive_filter_oe_out),
      .active_filter_drive_out(active_filter_drive_out),
      .active_filter_drive_oe_out(active_filter_drive_oe_out),
      .lock_indicator_out(lock_indicator_out),
      .pump_vco_out(pump_vco_out), .pump_ref_out(pump_ref_out),
      .ref_factor_out(ref_factor_out), .main_factor_out(main_factor_out));
   sps_host_model host_u (.clock_in(clock_in),
      .serial_clock_out(serial_clock_in), .serial_data_out(serial_data_in),
      .latch_load_strobe_out(latch_load_strobe_in));

   // ====================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic prog(input logic [15:0] v, input logic ctl, input logic ld);
      host_u.send(v, ctl ? 16 : 10, ctl, ld, 4 + rnd() % 4);
      if (ld && ctl) ref_exp = v;
      if (ld && !ctl) main_exp = v[9:0];
      repeat (8) @(negedge clock_in);
      check(ref_factor_out, ref_exp, "ref factor");
      check(main_factor_out, main_exp, "main factor");
   endtask
   task automatic div_test(input int f, input logic o);
      int q[$];
      rq.delete();
      vq.delete();
      osc_edges = 0;
      frq_edges = 0;
      osc_en = o;
      frq_en = !o;
      while ((o ? osc_edges : frq_edges) < 3 * f + 1) @(negedge clock_in);
      osc_en = 1'b0;
      frq_en = 1'b0;
      repeat (16) @(negedge clock_in);
      if (o) q = rq;
      else q = vq;
      check(q.size(), 4, "pulse count");
      for (int i = 1; i < q.size(); i++) begin
         check(q[i] - q[i-1], f, "pulse spacing");
      end
      $display("divider test done");
   endtask

   // ====================
   // Clock, timeout, edge sources, detector model
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(negedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   always @(negedge clock_in) begin
      ph = (ph + 1) % 6;
      if (ph == 0 && osc_en) begin
         osc_edges += !osc_amp_input_in;
         osc_amp_input_in = ~osc_amp_input_in;
      end
      if (ph == 0 && frq_en) begin
         frq_edges += !freq_in;
         freq_in = ~freq_in;
      end
      if (ref_side_compare_out) rq.push_back(osc_edges);
      if (vco_side_compare_out) vq.push_back(frq_edges);
      if (!rst_n_in) begin
         st = 0;
      end else if (ref_side_compare_out !== vco_side_compare_out) begin
         if (ref_side_compare_out) st = (st < 1) ? st + 1 : 1;
         else st = (st > -1) ? st - 1 : -1;
         wait_pd = 3;
      end else if (wait_pd > 0) begin
         wait_pd--;
         if (wait_pd == 0) check({passive_filter_out & passive_filter_oe_out,
            passive_filter_oe_out,
            active_filter_drive_out & active_filter_drive_oe_out,
            active_filter_drive_oe_out, lock_indicator_out, pump_vco_out,
            pump_ref_out}, st == 1 ? 7'h6a : (st < 0 ? 7'h39 : 7'h07),
            "phase outputs");
      end
   end

   // ====================
   // Main sequence
   initial begin
      logic [31:0] v;
      rst_n_in = 1'b0;
      osc_amp_input_in = 1'b0;
      freq_in = 1'b0;
      repeat (12) @(posedge clock_in);
      @(negedge clock_in) rst_n_in = 1'b1;
      prog(16'hffff, 1'b1, 1'b1);
      prog(16'h03ff, 1'b0, 1'b1);
      for (int n = 0; n < 6; n++) begin
         v = rnd();
         if (v[31]) prog(5 + v[15:0] % 65531, 1'b1, 1'b1);
         else prog(5 + v[9:0] % 1019, 1'b0, 1'b1);
      end
      prog(16'h1234, 1'b1, 1'b0);
      prog(16'h0155, 1'b0, 1'b0);
      $display("serial load test done");
      prog(16'h0007, 1'b1, 1'b1);
      prog(16'h0005, 1'b0, 1'b1);
      div_test(7, 1'b1);
      div_test(5, 1'b0);
      for (int k = 0; k < 2; k++) begin
         prog(k ? 16'd20 : 16'd5, 1'b1, 1'b1);
         prog(k ? 16'd5 : 16'd20, 1'b0, 1'b1);
         osc_en = 1'b1;
         frq_en = 1'b1;
         repeat (1500) @(negedge clock_in);
         osc_en = 1'b0;
         frq_en = 1'b0;
         $display("phase test done");
      end
      test_done();
   end
endmodule
